// ===== inc/rcsr_pkg.sv
package rcsr_pkg;

  // Register offsets (shared and channel pages)
  localparam logic [7:0] OFS_CLK_RST_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CHANNEL_SIGNAL_DETECT_STATUS       = 8'h01;
  localparam logic [7:0] OFS_LOAD_STATUS   = 8'h0b;
  localparam logic [7:0] OFS_BUS_TIMING    = 8'h0c;

  // Reset values
  localparam logic [7:0] RST_CLK_RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_BUS_TIMING    = 8'h91;
  localparam logic [7:0] RST_READ_ZERO     = 8'h00;

  // Channel control and signal detect status bit positions
  localparam int BIT_CORE_OFF      = 7;
  localparam int BIT_REGCLK_FORCE  = 6;
  localparam int BIT_REF_OFF       = 4;
  localparam int BIT_CORE_RST      = 3;
  localparam int BIT_REGS_DEFAULT  = 2;
  localparam int BIT_REF_RST       = 0;
  localparam int BIT_SIG_PRESENT   = 7;

  // Timing register fields
  localparam int BIT_FAST_RATE     = 7;
  localparam int POS_HOLD_LSB      = 4;
  localparam int POS_FILTER_LSB    = 0;

  // Load status encodings
  localparam logic [1:0] LOAD_BUSY = 2'h0;
  localparam logic [1:0] LOAD_FAIL = 2'h1;
  localparam logic [1:0] LOAD_OK   = 2'h2;

  // Load retry limit
  localparam logic [5:0] MAX_ATTEMPTS_M1 = 6'h3f;

  // Timing: 100 ns unit and clock period
  localparam int CLK_PERIOD_NS     = 100;
  localparam int UNIT_NS           = 100;
  localparam int UNIT_CYCLES       = (UNIT_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
  localparam int FAST_KHZ          = 400;
  localparam int STD_KHZ           = 100;
  localparam int CLK_KHZ           = 1000000 / CLK_PERIOD_NS;
  // Rounded up so the load bus never runs above its nominal rate
  localparam int FAST_HALF_CYCLES  = (CLK_KHZ + 2 * FAST_KHZ - 1)
                                     / (2 * FAST_KHZ);
  localparam int STD_HALF_CYCLES   = (CLK_KHZ + 2 * STD_KHZ - 1)
                                     / (2 * STD_KHZ);

  typedef struct packed {
    logic       write;
    logic       read;
    logic       channel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcsr_req_type;

  typedef struct packed {
    logic core_clk_en;
    logic core_rst;
    logic ref_clk_en;
    logic ref_rst;
    logic reg_clk_en;
  } rcsr_domain_type;

endpackage

// ===== logic/rcsr_regs.sv
module rcsr_regs
  import rcsr_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            reset,
  input  wire rcsr_req_type    req,
  output logic [7:0]           rdata,
  output logic                 rvalid,
  input  wire logic            load_attempt_start,
  input  wire logic            load_attempt_ok,
  input  wire logic            load_attempt_bad,
  input  wire logic            signal_detect_raw,
  input  wire logic            serial_clock_input,
  input  wire logic            serial_data_input,
  output logic                 load_retry_enable,
  output logic                 load_bus_tick,
  output logic                 serial_clock_clean,
  output logic                 serial_data_clean,
  output rcsr_domain_type      domain
);

  typedef enum logic [1:0] {
    LD_BUSY = 2'b00,
    LD_FAIL = 2'b01,
    LD_OK   = 2'b10
  } rcsr_load_type;

  logic [7:0]    ctrl;
  logic [7:0]    timing;
  logic [5:0]    load_attempt_count;
  rcsr_load_type load_state;
  logic [2:0]    sig_sync;
  logic          input_signal_present;
  logic [2:0]    scl_sync;
  logic [2:0]    sda_sync;
  logic [4:0]    scl_cnt;
  logic [4:0]    sda_cnt;
  logic [3:0]    hold_cnt;
  logic          sda_filt;
  logic [7:0]    bus_div;
  logic [7:0]    next_rdata;
  logic          access_active;

  function automatic logic hit(input rcsr_req_type r, input logic ch,
                               input logic [7:0] ofs);
    hit = (r.channel == ch) && (r.addr == ofs);
  endfunction

  wire logic [3:0] spike_filter_width = timing[POS_FILTER_LSB +: 4];
  wire logic [2:0] sda_hold_time      = timing[POS_HOLD_LSB +: 3];
  wire logic       fast_rate          = timing[BIT_FAST_RATE];
  wire logic       load_done_flag     = (load_state == LD_OK);
  wire logic       load_failed_flag   = (load_state == LD_FAIL);

  ////////////////////////////////////////////////////////////////////////////
  // Channel control register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl <= RST_CLK_RST_CTRL;
    end else if (ctrl[BIT_REGS_DEFAULT]) begin
      ctrl <= RST_CLK_RST_CTRL;
    end else if (req.write && hit(req, 1'b1, OFS_CLK_RST_CTRL)) begin
      ctrl <= req.wdata;
    end
  end

  // Shared timing register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timing <= RST_BUS_TIMING;
    end else if (req.write && hit(req, 1'b0, OFS_BUS_TIMING)) begin
      timing <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load outcome and attempt count
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      load_state         <= LD_BUSY;
      load_attempt_count <= 6'h00;
    end else if (load_state == LD_BUSY) begin
      if (load_attempt_start) begin
        load_attempt_count <= load_attempt_count + 6'h01;
      end
      if (load_attempt_ok) begin
        load_state <= LD_OK;
      end else if (load_attempt_bad &&
                   load_attempt_count == MAX_ATTEMPTS_M1 + 6'h01) begin
        load_state <= LD_FAIL;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      load_retry_enable <= 1'b0;
    end else begin
      load_retry_enable <= (load_state == LD_BUSY) &&
                           !(load_attempt_bad &&
                             load_attempt_count == MAX_ATTEMPTS_M1 + 6'h01)
                           && !load_attempt_ok;
    end
  end

  // Load bus rate tick
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_div       <= 8'h00;
      load_bus_tick <= 1'b0;
    // At or past limit, so a rate change never waits for a wrap
    end else if (bus_div >= 8'(fast_rate ? FAST_HALF_CYCLES - 1
                                         : STD_HALF_CYCLES - 1)) begin
      bus_div       <= 8'h00;
      load_bus_tick <= 1'b1;
    end else begin
      bus_div       <= bus_div + 8'h01;
      load_bus_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sig_sync <= 3'h0;
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      sig_sync <= {sig_sync[1:0], signal_detect_raw};
      scl_sync <= {scl_sync[1:0], serial_clock_input};
      sda_sync <= {sda_sync[1:0], serial_data_input};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      input_signal_present <= 1'b0;
    end else if (sig_sync[2] == sig_sync[1]) begin
      input_signal_present <= sig_sync[2];
    end
  end

  // Spike filter on serial clock
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scl_cnt            <= 5'h00;
      serial_clock_clean <= 1'b1;
    end else if (scl_sync[2] != scl_sync[1] ||
                 scl_sync[2] == serial_clock_clean) begin
      scl_cnt <= 5'h00;
    end else if (scl_cnt >= 5'(spike_filter_width * UNIT_CYCLES)) begin
      serial_clock_clean <= scl_sync[2];
      scl_cnt            <= 5'h00;
    end else begin
      scl_cnt <= scl_cnt + 5'h01;
    end
  end

  // Spike filter on serial data
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sda_cnt  <= 5'h00;
      sda_filt <= 1'b1;
    end else if (sda_sync[2] != sda_sync[1] ||
                 sda_sync[2] == sda_filt) begin
      sda_cnt <= 5'h00;
    end else if (sda_cnt >= 5'(spike_filter_width * UNIT_CYCLES)) begin
      sda_filt <= sda_sync[2];
      sda_cnt  <= 5'h00;
    end else begin
      sda_cnt <= sda_cnt + 5'h01;
    end
  end

  // Data hold delay
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hold_cnt          <= 4'h0;
      serial_data_clean <= 1'b1;
    end else if (sda_filt == serial_data_clean) begin
      hold_cnt <= 4'h0;
    end else if (hold_cnt >= 4'(sda_hold_time * UNIT_CYCLES)) begin
      serial_data_clean <= sda_filt;
      hold_cnt          <= 4'h0;
    end else begin
      hold_cnt <= hold_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Domain gating and resets
  assign access_active = req.read || req.write;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      domain <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    end else begin
      domain.core_clk_en <= !ctrl[BIT_CORE_OFF];
      domain.core_rst    <= ctrl[BIT_CORE_RST];
      domain.ref_clk_en  <= !ctrl[BIT_REF_OFF];
      domain.ref_rst     <= ctrl[BIT_REF_RST];
      domain.reg_clk_en  <= ctrl[BIT_REGCLK_FORCE] || access_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    next_rdata = RST_READ_ZERO;
    if (hit(req, 1'b1, OFS_CLK_RST_CTRL)) begin
      next_rdata = ctrl;
    end else if (hit(req, 1'b1, OFS_CHANNEL_SIGNAL_DETECT_STATUS)) begin
      next_rdata[BIT_SIG_PRESENT] = input_signal_present;
    end else if (hit(req, 1'b0, OFS_LOAD_STATUS)) begin
      next_rdata = {load_done_flag, load_failed_flag,
                    load_attempt_count};
    end else if (hit(req, 1'b0, OFS_BUS_TIMING)) begin
      next_rdata = timing;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata  <= RST_READ_ZERO;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.read;
      if (req.read) begin
        rdata <= next_rdata;
      end
    end
  end

endmodule

// ===== bench/rcsr_regs_chk.sv
module rcsr_regs_chk
  import rcsr_pkg::*;
(
  input wire logic            clk_sys,
  input wire logic            reset,
  input wire rcsr_req_type    req,
  input wire logic [7:0]      rdata,
  input wire logic            rvalid,
  input wire logic            load_bus_tick,
  input wire rcsr_domain_type domain
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic wc;
  assign wc = req.write && req.channel && req.addr == 8'h00;
  property p_rv; req.read |=> rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read unanswered");
  property p_rv0; !req.read |=> !rvalid; endproperty
  a_rv0: assert property (p_rv0) else $error("stray answer");
  property p_code; rvalid && $past(req.addr) == 8'h0b
    && !$past(req.channel) |-> rdata[7:6] != 2'b11; endproperty
  a_code: assert property (p_code) else $error("bad code");
  property p_sig; rvalid && $past(req.channel)
    && $past(req.addr) == 8'h01 |-> rdata[6:0] == 7'h00; endproperty
  a_sig: assert property (p_sig) else $error("bad detect");
  property p_rd0; req.read && (req.channel ? req.addr > 8'h01 :
    req.addr != 8'h0b && req.addr != 8'h0c) |=> rdata == 8'h00;
  endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped data");
  property p_core; wc |-> ##2 domain.core_clk_en == !$past(req.wdata[7], 2)
    && domain.core_rst == $past(req.wdata[3], 2); endproperty
  a_core: assert property (p_core) else $error("core");
  property p_ref; wc |-> ##2 domain.ref_clk_en == !$past(req.wdata[4], 2)
    && domain.ref_rst == $past(req.wdata[0], 2); endproperty
  a_ref: assert property (p_ref) else $error("ref");
  property p_force; wc && req.wdata[6] |-> ##2 domain.reg_clk_en;
  endproperty
  a_force: assert property (p_force) else $error("force");
  property p_dflt; wc && req.wdata[2] ##1 (!req.write)[*2] |=>
    domain.core_clk_en && domain.ref_clk_en && !domain.core_rst
    && !domain.ref_rst; endproperty
  a_dflt: assert property (p_dflt) else $error("defaults");
  property p_tick; load_bus_tick |=> (!load_bus_tick)[*4]; endproperty
  a_tick: assert property (p_tick) else $error("tick gap");
  c_dflt: cover property (wc && req.wdata[2]);
  c_stat: cover property (req.read && req.addr == 8'h0b);
  c_tick: cover property (load_bus_tick);
endmodule
////////////////////////////////////////////////////////////////////////
bind rcsr_regs rcsr_regs_chk i_chk (.clk_sys(clk_sys), .reset(reset),
  .req(req), .rdata(rdata), .rvalid(rvalid),
  .load_bus_tick(load_bus_tick), .domain(domain));

// ===== bench/rcsr_eeprom.sv
module rcsr_eeprom (
  input wire logic       clk_sys,
  input wire logic       retry,
  input wire logic       go,
  input wire logic [6:0] n_bad,
  output logic           start,
  output logic           ok,
  output logic           bad,
  output logic           busy
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic hit(input int k);
    @(posedge clk_sys);
    #10 {start, ok, bad} = 3'b100 >> k;
    @(posedge clk_sys);
    #10 {start, ok, bad} = 3'b000;
  endtask
  initial begin
    {start, ok, bad, busy} = 4'h0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      for (int i = 0; i <= n_bad && retry; i++) begin
        hit(0);
        repeat (2) @(posedge clk_sys);
        hit(i < n_bad ? 2 : 1);
        repeat (3) @(posedge clk_sys);
        #10;
      end
      busy = 1'b0;
    end
  end
endmodule

// ===== bench/testbench.sv
module testbench
  import rcsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset, rvalid, start, ok, bad, sd_raw, go, busy, retry;
  logic clk_pin, dat_pin, clk_cln, dat_cln, tick;
  logic [7:0] rdata, d, v;
  logic [6:0] n_bad;
  logic [17:0] t [6];
  rcsr_req_type req;
  rcsr_domain_type domain;
  int num_errors, checks, n, m, seed = 32'h89ac;
  rcsr_regs i_rcsr_regs (.clk_sys(clk_sys), .reset(reset), .req(req),
    .rdata(rdata), .rvalid(rvalid), .load_attempt_start(start),
    .load_attempt_ok(ok), .load_attempt_bad(bad),
    .signal_detect_raw(sd_raw), .serial_clock_input(clk_pin),
    .serial_data_input(dat_pin), .load_retry_enable(retry),
    .load_bus_tick(tick), .serial_clock_clean(clk_cln),
    .serial_data_clean(dat_cln), .domain(domain));
  rcsr_eeprom i_rcsr_eeprom (.clk_sys(clk_sys), .retry(retry), .go(go),
    .n_bad(n_bad), .start(start), .ok(ok), .bad(bad), .busy(busy));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #10;
  endtask
  task automatic wr(input logic c, input logic [7:0] a, w);
    cyc(0);
    @(posedge clk_sys);
    #10 req = '{1'b1, 1'b0, c, a, w};
    cyc(1);
    req.write = 1'b0;
  endtask
  task automatic rd(input logic c, input logic [7:0] a);
    @(posedge clk_sys);
    #10 req = '{1'b0, 1'b1, c, a, 8'h00};
    cyc(1);
    req.read = 1'b0;
    d = rdata;
    chk(rvalid, 1'b1);
  endtask
  task automatic gap(output int g);
    for (g = 0; tick !== 1'b1 && g < 120; g++) cyc(1);
    cyc(1);
    for (g = 1; tick !== 1'b1 && g < 120; g++) cyc(1);
  endtask
  task automatic pin(input int w, output logic [1:0] lo);
    lo = 2'b00;
    {clk_pin, dat_pin} = 2'b00;
    for (int k = 0; k < w + 8; k++) begin
      cyc(1);
      if (k == w - 1) {clk_pin, dat_pin} = 2'b11;
      lo = lo | ~{clk_cln, dat_cln};
    end
  endtask
  task automatic lag(input logic [7:0] cfg, output int g);
    wr(0, 8'h0c, cfg);
    {clk_pin, dat_pin} = 2'b00;
    for (g = 0; clk_cln !== 1'b0 && g < 40; g++) cyc(1);
    for (g = 0; dat_cln !== 1'b0 && g < 40; g++) cyc(1);
    cyc(4);
    {clk_pin, dat_pin} = 2'b11;
    cyc(20);
  endtask
  task automatic load(input int nb);
    rd(0, 8'h0b);
    chk(d, 8'h00);
    n_bad = 7'(nb);
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (int k = 0; busy && k < 2000; k++) cyc(1);
    n = nb < 64 ? nb + 1 : 64;
    rd(0, 8'h0b);
    chk(d, {nb < 64, nb >= 64, 6'(n)});
    if (nb >= 64) chk(retry, 1'b0);
  endtask
  initial begin
    #1000000;
    num_errors++;
    summarize;
  end
  initial begin
    {req, sd_raw, go, n_bad} = '0;
    {clk_pin, dat_pin} = 2'b11;
    reset = 1'b1;
    t = '{18'h30b00, 18'h00c91, 18'h10000, 18'h30100, 18'h20500, 18'h30200};
    repeat (5) @(posedge clk_sys);
    #10 reset = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(t[i][16], t[i][15:8]);
      chk(d, t[i][7:0]);
      if (t[i][17]) begin
        wr(t[i][16], t[i][15:8], 8'hff);
        rd(t[i][16], t[i][15:8]);
        chk(d, t[i][7:0]);
      end
    end
    v = 8'($random(seed));
    wr(0, 8'h0c, v);
    rd(0, 8'h0c);
    chk(d, v);
    for (int f = 0; f < 2; f++) begin
      wr(0, 8'h0c, f ? 8'h91 : 8'h11);
      gap(n);
      gap(n);
      chk(8'(n), f ? 8'h0d : 8'h32);
    end
    wr(0, 8'h0c, 8'h83);
    pin(3, v[1:0]);
    chk(v[1:0], 2'b00);
    pin(10, v[1:0]);
    chk(v[1:0], 2'b11);
    lag(8'h80, n);
    lag(8'hb0, m);
    chk(8'(m - n), 8'h03);
    repeat (8) begin
      v = 8'($random(seed)) & 8'hd9;
      wr(1, 8'h00, v);
      cyc(1);
      chk(domain[4:1], {~v[7], v[3], ~v[4], v[0]});
      if (v[6]) chk(domain.reg_clk_en, 1'b1);
      rd(1, 8'h00);
      chk(d, v);
    end
    wr(1, 8'h00, 8'hdd);
    cyc(3);
    chk(domain[4:1], 4'ha);
    rd(1, 8'h00);
    chk(d, 8'h00);
    for (int s = 0; s < 2; s++) begin
      sd_raw = s == 0;
      cyc(6);
      rd(1, 8'h01);
      chk(d, {sd_raw, 7'h00});
    end
    load($unsigned($random(seed)) % 8);
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    cyc(3);
    load(64);
    summarize;
  end
endmodule
